// ==== dv/ext_memory_model.sv ====
`timescale 1ns/10ps
module ext_memory_model (
   input wire logic clk,
   input wire logic activeHigh,
   input wire logic combined,
   input wire logic muxed,
   input wire logic readPin,
   input wire logic writePin,
   input wire logic bytePin,
   input wire logic [15:0] addrPin,
   input wire logic [7:0] dataOut,
   input wire logic dataOe,
   output logic [7:0] dataIn
);
   logic [7:0] mem [256];
   logic [7:0] lat = 8'h00;
   logic [7:0] last = 8'h00;
   wire rdA = readPin == activeHigh;
   wire wrA = writePin == activeHigh;
   wire beA = bytePin == activeHigh;
   wire latA = addrPin[0] == activeHigh;
   wire rd = combined ? rdA & wrA : rdA;
   wire wr = combined ? !rdA & wrA : wrA;
   wire [7:0] idx = (muxed ? lat : addrPin[7:0]) ^ {7'h00, beA};
   // Released bus shows a toggling pattern so a stale capture cannot pass
   assign dataIn = rd ? mem[idx] : ~last;
   initial begin
      for (int i = 0; i < 256; i++) mem[i] = i[7:0] ^ 8'h3c;
   end
   always @(posedge clk) begin
      last <= dataIn;
      if (muxed && latA && dataOe) lat <= dataOut;
      if (wr && dataOe) mem[idx] <= dataOut;
   end
endmodule : ext_memory_model

// ==== dv/parallel_master_bus_port_asserts.sv ====
`timescale 1ns/10ps
module parallel_master_bus_port_asserts import bus_port_pkg::*; (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   input wire logic dataOe,
   input wire logic readPin,
   input wire logic readPinEn,
   input wire logic writePin,
   input wire logic writePinEn,
   input wire logic bytePin,
   input wire logic bytePinEn,
   input wire logic [15:0] addrPinEn,
   input wire logic irqReq,
   input wire logic busy
);
   logic [7:0] cHi, cLo, mHi, peLo, peHi;
   wire wrEn = psel & penable & pwrite & pready;
   wire split = mHi[1:0] == 2'h2;
   wire rdAct = readPin == cLo[CL_READ_POL];
   wire wrAct = writePin == cLo[CL_WRITE_POL];
   wire beAct = bytePin == cLo[CL_BYTE_POL];
   // Configuration rebuilt from bus writes, since registers are not visible
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cHi <= RST_REG;
         cLo <= RST_REG;
         mHi <= RST_REG;
         peLo <= RST_REG;
         peHi <= RST_REG;
      end else if (wrEn) begin
         case (paddr)
            OFS_CTRL_HI: cHi <= pwdata[7:0];
            OFS_CTRL_LO: cLo <= pwdata[7:0];
            OFS_MODE_HI: mHi <= pwdata[7:0];
            OFS_PIN_EN_LO: peLo <= pwdata[7:0];
            OFS_PIN_EN_HI: peHi <= pwdata[7:0];
            default: ;
         endcase
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   a_pin_enable: assert property ({readPinEn, writePinEn, bytePinEn} == ({3{cHi[7]}} & cHi[2:0]))
      else $error("control pin enables wrong");
   a_addr_enable: assert property (addrPinEn == ({16{cHi[CH_ENABLE]}} & {peHi, peLo}))
      else $error("address pin enables wrong");
   a_split_excl: assert property (split |-> !(rdAct && wrAct))
      else $error("read and write strobes together");
   a_read_release: assert property (split && rdAct |-> !dataOe)
      else $error("data bus driven during read strobe");
   a_write_drive: assert property (split && wrAct |-> dataOe)
      else $error("data bus not driven during write strobe");
   a_narrow_byte: assert property (!mHi[MH_WIDE] |-> !beAct)
      else $error("byte enable in byte mode");
   a_busy_bounded: assert property ($rose(busy) |-> ##[1:60] !busy)
      else $error("busy too long");
   a_irq_cause: assert property (irqReq |-> !$past(busy) && mHi[6:5] == IRQ_EACH)
      else $error("request pulse without finished transfer");
endmodule : parallel_master_bus_port_asserts

bind parallel_master_bus_port parallel_master_bus_port_asserts chk_u (.clk(clk),
   .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .pready(pready), .dataOe(dataOe), .readPin(readPin),
   .readPinEn(readPinEn), .writePin(writePin), .writePinEn(writePinEn), .bytePin(bytePin),
   .bytePinEn(bytePinEn), .addrPinEn(addrPinEn), .irqReq(irqReq), .busy(busy));

// ==== dv/parallel_master_bus_port_test.sv ====
`timescale 1ns/10ps
module parallel_master_bus_port_test import bus_port_pkg::*; ;
   typedef struct packed {
      logic [1:0] mode, mux, step;
      logic wide, pol, wr;
      logic [7:0] wcfg;
      logic [15:0] addr, data;
   } row_t;
   logic clk, arst_n, psel, penable, pwrite, pready, pslverr, dataOe, irqReq, busy;
   logic readPin, readPinEn, writePin, writePinEn, bytePin, bytePinEn;
   logic [7:0] paddr, dataIn, dataOut, a, ad;
   logic [31:0] pwdata, prdata, rdv;
   logic [15:0] addrPin, addrPinEn, n;
   logic pol, combined, muxed, errv, irqs;
   logic [7:0] expMem [256];
   row_t rows [8];
   row_t r;
   int num_errors = 0;
   int n_compared = 0;
   int cycles = 0;
   int bc;
   parallel_master_bus_port dut_u (.clk(clk), .arst_n(arst_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .dataIn(dataIn), .dataOut(dataOut),
      .dataOe(dataOe), .readPin(readPin), .readPinEn(readPinEn), .writePin(writePin),
      .writePinEn(writePinEn), .bytePin(bytePin), .bytePinEn(bytePinEn),
      .addrPin(addrPin), .addrPinEn(addrPinEn), .irqReq(irqReq), .busy(busy));
   ext_memory_model mem_u (.clk(clk), .activeHigh(pol), .combined(combined), .muxed(muxed),
      .readPin(readPin), .writePin(writePin), .bytePin(bytePin), .addrPin(addrPin),
      .dataOut(dataOut), .dataOe(dataOe), .dataIn(dataIn));
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   task end_of_test();
      $display("compared %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : end_of_test
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         end_of_test();
      end
   end
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         num_errors++;
         $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task apb(input logic w, input logic [7:0] ad8, input logic [7:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= ad8;
      pwdata <= {24'h0, d};
      @(posedge clk);
      penable <= 1'b1;
      // Ends once pready is sampled high; the bench timeout ends a hung wait
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rdv = prdata;
      errv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task wr(input logic [7:0] ad8, input logic [7:0] d);
      apb(1'b1, ad8, d);
   endtask : wr
   task rdr(input logic [7:0] ad8);
      apb(1'b0, ad8, 8'h00);
   endtask : rdr
   // Counts busy cycles, then samples the request pulse one cycle later
   task waitDone();
      bc = 0;
      repeat (100) begin
         @(negedge clk);
         if (busy !== 1'b1) break;
         bc++;
      end
      @(negedge clk);
      irqs = irqReq;
   endtask : waitDone
   task doReset();
      arst_n <= 1'b0;
      repeat (5) @(posedge clk);
      arst_n <= 1'b1;
   endtask : doReset
   task cfg(input row_t c);
      pol = c.pol;
      combined = c.mode == MODE_COMBINED;
      muxed = c.mux != MUX_DEMUX;
      wr(OFS_CTRL_HI, {1'b1, 2'b00, c.mux, 3'b111});
      wr(OFS_CTRL_LO, {2'b00, {6{c.pol}}});
      wr(OFS_MODE_HI, {1'b0, IRQ_EACH, c.step, c.wide, c.mode});
      wr(OFS_WAIT_CFG, c.wcfg);
      wr(OFS_PIN_EN_LO, 8'hff);
      wr(OFS_PIN_EN_HI, 8'hff);
      wr(OFS_ADDR_LO, c.addr[7:0]);
      wr(OFS_ADDR_HI, c.addr[15:8]);
      wr(OFS_DIN_HI, c.data[15:8]);
   endtask : cfg
   // Middle wait of zero cancels the begin and end waits
   function automatic int expBusy(input row_t c);
      int m;
      int pad;
      m = c.wcfg[5:2];
      pad = (m == 0) ? 0 : c.wcfg[7:6] + c.wcfg[1:0];
      return (c.mux == MUX_FULL ? 2 : c.mux == MUX_PART) + (c.wide + 1) * (pad + 1 + m) - 1;
   endfunction : expBusy
   initial begin
      {psel, penable, pwrite, pol, combined, muxed} = '0;
      paddr = 8'h00;
      pwdata = 32'h0;
      arst_n = 1'b0;
      for (int i = 0; i < 256; i++) expMem[i] = i[7:0] ^ 8'h3c;
      rows[0] = '{2'h2, 2'h0, 2'h1, 1'b0, 1'b0, 1'b1, 8'h00, 16'h0012, 16'h00a5};
      rows[1] = '{2'h2, 2'h0, 2'h0, 1'b0, 1'b0, 1'b0, 8'h00, 16'h0012, 16'h0000};
      rows[2] = '{2'h2, 2'h1, 2'h2, 1'b0, 1'b1, 1'b0, 8'h49, 16'h0134, 16'h0000};
      rows[3] = '{2'h3, 2'h2, 2'h1, 1'b1, 1'b0, 1'b1, 8'h06, 16'h0256, 16'h1234};
      rows[4] = '{2'h3, 2'h1, 2'h0, 1'b1, 1'b0, 1'b0, 8'hc3, 16'h0256, 16'h0000};
      rows[5] = '{2'h2, 2'h2, 2'h1, 1'b1, 1'b1, 1'b0, 8'h00, 16'h0256, 16'h0000};
      rows[6] = '{2'h2, 2'h0, 2'h2, 1'b0, 1'b0, 1'b1, 8'h3c, 16'h0000, 16'h00c7};
      rows[7] = '{2'h2, 2'h2, 2'h1, 1'b0, 1'b0, 1'b1, 8'h3c, 16'hffff, 16'h0011};
      doReset();
      for (int i = 0; i < 7; i++) begin
         r = rows[i];
         cfg(r);
         a = r.addr[7:0];
         if (r.wr) begin
            wr(OFS_DIN_LO, r.data[7:0]);
            waitDone();
            chk(bc, expBusy(r));
            expMem[a] = r.data[7:0];
            if (r.wide) expMem[a ^ 8'h01] = r.data[15:8];
            chk(mem_u.mem[a], expMem[a]);
            chk(mem_u.mem[a ^ 8'h01], expMem[a ^ 8'h01]);
            n = 16'h1;
         end else begin
            rdr(OFS_DIN_LO);
            waitDone();
            chk(bc, expBusy(r));
            rdr(OFS_DIN_HI);
            if (r.wide) chk(rdv, expMem[a ^ 8'h01]);
            rdr(OFS_DIN_LO);
            chk(rdv, expMem[a]);
            waitDone();
            n = 16'h2;
         end
         chk(irqs, 1'b1);
         rdr(OFS_ADDR_LO);
         ad = rdv[7:0];
         rdr(OFS_ADDR_HI);
         // The address wraps at 16 bits
         chk({rdv[7:0], ad}, 16'(r.step == STEP_INC ? r.addr + n :
            r.step == STEP_DEC ? r.addr - n : r.addr));
         $display("row %0d done", i);
      end
      cfg(rows[7]);
      wr(OFS_CTRL_LO, 8'h80);
      wr(OFS_DIN_LO, 8'h11);
      @(negedge clk);
      @(negedge clk);
      chk(dataOut, 8'h3f);
      chk(addrPin[15:14], 2'b00);
      wr(OFS_DIN_LO, 8'h77);
      waitDone();
      chk(addrPin[15:14], 2'b11);
      rdr(OFS_ADDR_HI);
      chk(rdv, 32'hc0);
      rdr(OFS_DIN_LO);
      chk(rdv, 32'h11);
      chk(mem_u.mem[8'hff], 8'h11);
      // The data read above started a bus read; let it and its request pulse finish
      waitDone();
      $display("select and busy test done");
      for (int j = 0; j < 2; j++) begin
         wr(OFS_CTRL_HI, j ? 8'h87 : 8'h07);
         wr(OFS_MODE_HI, 8'h21);
         wr(OFS_DIN_LO, 8'h55);
         waitDone();
         chk(bc, 0);
         chk(irqs, 1'b0);
      end
      $display("disabled test done");
      @(posedge clk);
      doReset();
      chk({readPin, writePin, bytePin}, 3'b111);
      for (int o = 0; o < 40; o += 4) begin
         rdr(o[7:0]);
         chk(rdv, {24'h0, RST_REG});
      end
      rdr(8'h28);
      chk(errv, 1'b1);
      $display("reset test done");
      end_of_test();
   end
endmodule : parallel_master_bus_port_test

// ==== verilog/addr_stepper.sv ====
`timescale 1ns/10ps
module addr_stepper import bus_port_pkg::*; (
   input wire logic [15:0] addr,
   input wire logic [1:0] stepMode,
   input wire logic [1:0] csFunc,
   output logic [15:0] steppedAddr
);
   // Bits used as chip selects keep their value; the carry into them is simply dropped
   wire [15:0] keepMask = {selTwoOn(csFunc), selOneOn(csFunc), 14'h0000};
   wire [15:0] upAddr = addr + 16'h0001;
   wire [15:0] downAddr = addr - 16'h0001;
   wire [15:0] moved = (stepMode == STEP_INC) ? upAddr :
      (stepMode == STEP_DEC) ? downAddr : addr;

   assign steppedAddr = (moved & ~keepMask) | (addr & keepMask);
endmodule : addr_stepper

// ==== verilog/bus_port_pkg.sv ====
package bus_port_pkg;

   localparam logic [7:0] OFS_CTRL_HI = 8'h00;
   localparam logic [7:0] OFS_CTRL_LO = 8'h04;
   localparam logic [7:0] OFS_ADDR_LO = 8'h08;
   localparam logic [7:0] OFS_ADDR_HI = 8'h0c;
   localparam logic [7:0] OFS_DIN_LO = 8'h10;
   localparam logic [7:0] OFS_DIN_HI = 8'h14;
   localparam logic [7:0] OFS_MODE_HI = 8'h18;
   localparam logic [7:0] OFS_WAIT_CFG = 8'h1c;
   localparam logic [7:0] OFS_PIN_EN_LO = 8'h20;
   localparam logic [7:0] OFS_PIN_EN_HI = 8'h24;

   localparam logic [7:0] RST_REG = 8'h00;

   // control_high_reg fields
   localparam int CH_ENABLE = 7;
   localparam int CH_MUX = 3;
   localparam int CH_BYTE_PIN_EN = 2;
   localparam int CH_WRITE_PIN_EN = 1;
   localparam int CH_READ_PIN_EN = 0;
   // control_low_reg fields
   localparam int CL_CS_FUNC = 6;
   localparam int CL_LATCH_POL = 5;
   localparam int CL_CS2_POL = 4;
   localparam int CL_CS1_POL = 3;
   localparam int CL_BYTE_POL = 2;
   localparam int CL_WRITE_POL = 1;
   localparam int CL_READ_POL = 0;
   // mode_high_reg fields
   localparam int MH_BUSY = 7;
   localparam int MH_IRQ = 5;
   localparam int MH_STEP = 3;
   localparam int MH_WIDE = 2;
   localparam int MH_MODE = 0;
   // master_wait_config fields
   localparam int MW_BEGIN = 6;
   localparam int MW_MIDDLE = 2;
   localparam int MW_END = 0;
   // high_address_byte select bits
   localparam int AH_SEL_ONE = 6;
   localparam int AH_SEL_TWO = 7;

   localparam logic [1:0] MUX_DEMUX = 2'h0;
   localparam logic [1:0] MUX_PART = 2'h1;
   localparam logic [1:0] MUX_FULL = 2'h2;
   localparam logic [1:0] STEP_INC = 2'h1;
   localparam logic [1:0] STEP_DEC = 2'h2;
   localparam logic [1:0] MODE_COMBINED = 2'h3;
   localparam logic [1:0] IRQ_EACH = 2'h1;

   typedef enum logic [5:0] {
      S_IDLE = 6'h01,
      S_ALO = 6'h02,
      S_AHI = 6'h04,
      S_SETUP = 6'h08,
      S_STROBE = 6'h10,
      S_HOLD = 6'h20
   } seq_state_t;

   function automatic logic selOneOn(input logic [1:0] csFunc);
      return csFunc[1];
   endfunction : selOneOn

   function automatic logic selTwoOn(input logic [1:0] csFunc);
      return |csFunc;
   endfunction : selTwoOn

endpackage : bus_port_pkg

// ==== verilog/parallel_master_bus_port.sv ====
// The APB register port and the address map were decided locally.
`timescale 1ns/10ps
module parallel_master_bus_port import bus_port_pkg::*; (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [7:0] dataIn,
   output logic [7:0] dataOut,
   output logic dataOe,
   output logic readPin,
   output logic readPinEn,
   output logic writePin,
   output logic writePinEn,
   output logic bytePin,
   output logic bytePinEn,
   output logic [15:0] addrPin,
   output logic [15:0] addrPinEn,
   output logic irqReq,
   output logic busy
);

   // Software registers
   logic [7:0] ctrlHi;
   logic [7:0] ctrlLo;
   logic [7:0] addrLo;
   logic [7:0] addrHi;
   logic [7:0] dinLo;
   logic [7:0] dinHi;
   logic [6:0] modeHi;
   logic [7:0] waitCfg;
   logic [7:0] pinEnLo;
   logic [7:0] pinEnHi;

   // Sequencer state
   seq_state_t state;
   seq_state_t next_state;
   logic [3:0] cnt;
   logic [3:0] next_cnt;
   logic byteSel;
   logic next_byte;
   logic opRead;

   port_sig_if sig();

   // APB decode
   wire apbDo = psel & penable;
   wire apbWr = apbDo & pwrite;
   wire apbRd = apbDo & ~pwrite;
   wire hitCtrlHi = (paddr == OFS_CTRL_HI);
   wire hitCtrlLo = (paddr == OFS_CTRL_LO);
   wire hitAddrLo = (paddr == OFS_ADDR_LO);
   wire hitAddrHi = (paddr == OFS_ADDR_HI);
   wire hitDinLo = (paddr == OFS_DIN_LO);
   wire hitDinHi = (paddr == OFS_DIN_HI);
   wire hitModeHi = (paddr == OFS_MODE_HI);
   wire hitWaitCfg = (paddr == OFS_WAIT_CFG);
   wire hitPinEnLo = (paddr == OFS_PIN_EN_LO);
   wire hitPinEnHi = (paddr == OFS_PIN_EN_HI);
   wire mapped = hitCtrlHi | hitCtrlLo | hitAddrLo | hitAddrHi | hitDinLo | hitDinHi |
      hitModeHi | hitWaitCfg | hitPinEnLo | hitPinEnHi;

   // Configuration fields
   wire [1:0] muxSel = ctrlHi[CH_MUX +: 2];
   wire [1:0] csFunc = ctrlLo[CL_CS_FUNC +: 2];
   wire [1:0] masterMode = modeHi[MH_MODE +: 2];
   wire [1:0] stepMode = modeHi[MH_STEP +: 2];
   wire [1:0] irqMode = modeHi[MH_IRQ +: 2];
   wire wide = modeHi[MH_WIDE];
   wire [1:0] begin_wait_field = waitCfg[MW_BEGIN +: 2];
   wire [3:0] middle_wait_field = waitCfg[MW_MIDDLE +: 4];
   wire [1:0] end_wait_field = waitCfg[MW_END +: 2];

   // Wait shaping: begin and end waits only count when the middle wait is non-zero
   wire waitsOn = (middle_wait_field != 4'h0);
   wire useSetup = waitsOn & (begin_wait_field != 2'h0);
   wire useHold = waitsOn & (end_wait_field != 2'h0);
   wire [3:0] setupCnt = {2'h0, begin_wait_field} - 4'h1;
   wire [3:0] holdCnt = {2'h0, end_wait_field} - 4'h1;

   wire cntZero = (cnt == 4'h0);
   wire inData = (state == S_SETUP) | (state == S_STROBE) | (state == S_HOLD);
   wire moreByte = wide & ~byteSel;
   wire byteDone = cntZero & (((state == S_STROBE) & ~useHold) | (state == S_HOLD));
   wire lastCycle = byteDone & ~moreByte;

   // Busy covers every cycle of a transfer except its last
   assign busy = (state != S_IDLE) & ~lastCycle;

   // A start needs the module on and a master mode; while busy it is dropped
   wire startOk = ctrlHi[CH_ENABLE] & masterMode[1] & ~busy;
   wire startRd = apbRd & hitDinLo & startOk;
   wire startWr = apbWr & hitDinLo & startOk;
   wire startAny = startRd | startWr;

   wire addrFirst = (muxSel == MUX_PART) | (muxSel == MUX_FULL);
   seq_state_t entryState;
   seq_state_t launchState;
   assign entryState = useSetup ? S_SETUP : S_STROBE;
   wire [3:0] entryCnt = useSetup ? setupCnt : middle_wait_field;
   assign launchState = addrFirst ? S_ALO : entryState;

   // Read data is taken on the final strobe cycle, when the far side has had longest
   wire capture = (state == S_STROBE) & cntZero & opRead;

   always_comb begin
      next_state = state;
      next_cnt = cnt;
      next_byte = byteSel;
      unique case (state)
         S_IDLE: begin
            if (startAny) begin
               next_state = launchState;
               next_cnt = entryCnt;
               next_byte = 1'b0;
            end
         end
         S_ALO: begin
            if (muxSel == MUX_FULL) begin
               next_state = S_AHI;
            end else begin
               next_state = entryState;
               next_cnt = entryCnt;
            end
         end
         S_AHI: begin
            next_state = entryState;
            next_cnt = entryCnt;
         end
         S_SETUP: begin
            if (cntZero) begin
               next_state = S_STROBE;
               next_cnt = middle_wait_field;
            end else begin
               next_cnt = cnt - 4'h1;
            end
         end
         S_STROBE, S_HOLD: begin
            if (!cntZero) begin
               next_cnt = cnt - 4'h1;
            end else if (state == S_STROBE && useHold) begin
               next_state = S_HOLD;
               next_cnt = holdCnt;
            end else if (moreByte) begin
               // The address phase is shared by both bytes of a halfword
               next_state = entryState;
               next_cnt = entryCnt;
               next_byte = 1'b1;
            end else if (startAny) begin
               next_state = launchState;
               next_cnt = entryCnt;
               next_byte = 1'b0;
            end else begin
               next_state = S_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state <= S_IDLE;
         cnt <= 4'h0;
         byteSel <= 1'b0;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
         byteSel <= next_byte;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         opRead <= 1'b0;
      end else if (startAny) begin
         opRead <= startRd;
      end
   end

   // Address stepping after the last cycle; a software write in that cycle wins
   logic [15:0] steppedAddr;
   addr_stepper stepper (
      .addr({addrHi, addrLo}),
      .stepMode(stepMode),
      .csFunc(csFunc),
      .steppedAddr(steppedAddr)
   );
   wire doStep = lastCycle;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         addrLo <= RST_REG;
      end else if (apbWr && hitAddrLo) begin
         addrLo <= pwdata[7:0];
      end else if (doStep) begin
         addrLo <= steppedAddr[7:0];
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         addrHi <= RST_REG;
      end else if (apbWr && hitAddrHi) begin
         addrHi <= pwdata[7:0];
      end else if (doStep) begin
         addrHi <= steppedAddr[15:8];
      end
   end

   // Data registers: software writes dinLo only when a write starts, dinHi when not busy, except in the cycle a read captures into it
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         dinLo <= RST_REG;
      end else if (startWr) begin
         dinLo <= pwdata[7:0];
      end else if (capture && !byteSel) begin
         dinLo <= dataIn;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         dinHi <= RST_REG;
      end else if (capture && byteSel) begin
         dinHi <= dataIn;
      end else if (apbWr && hitDinHi && !busy) begin
         dinHi <= pwdata[7:0];
      end
   end

   // Plain configuration registers
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ctrlHi <= RST_REG;
         ctrlLo <= RST_REG;
         modeHi <= RST_REG[6:0];
         waitCfg <= RST_REG;
         pinEnLo <= RST_REG;
         pinEnHi <= RST_REG;
      end else if (apbWr) begin
         if (hitCtrlHi) ctrlHi <= pwdata[7:0];
         if (hitCtrlLo) ctrlLo <= pwdata[7:0];
         if (hitModeHi) modeHi <= pwdata[6:0];
         if (hitWaitCfg) waitCfg <= pwdata[7:0];
         if (hitPinEnLo) pinEnLo <= pwdata[7:0];
         if (hitPinEnHi) pinEnHi <= pwdata[7:0];
      end
   end

   // One request pulse per finished transfer, registered
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         irqReq <= 1'b0;
      end else begin
         irqReq <= lastCycle & (irqMode == IRQ_EACH);
      end
   end

   // APB answer: zero wait states, error on an unmapped word
   assign pready = 1'b1;
   assign pslverr = apbDo & ~mapped;
   wire [7:0] rdByte =
      hitCtrlHi ? ctrlHi :
      hitCtrlLo ? ctrlLo :
      hitAddrLo ? addrLo :
      hitAddrHi ? addrHi :
      hitDinLo ? dinLo :
      hitDinHi ? dinHi :
      hitModeHi ? {busy, modeHi} :
      hitWaitCfg ? waitCfg :
      hitPinEnLo ? pinEnLo :
      hitPinEnHi ? pinEnHi : 8'h00;
   assign prdata = {24'h000000, rdByte};

   // Logical strobe levels towards the pin driver
   wire active = (state != S_IDLE);
   wire strobeNow = (state == S_STROBE);
   assign sig.combined = (masterMode == MODE_COMBINED);
   assign sig.dirRead = active & opRead;
   assign sig.enStrobe = strobeNow;
   assign sig.rdStrobe = strobeNow & opRead;
   assign sig.wrStrobe = strobeNow & ~opRead;
   assign sig.byteEn = inData & byteSel;
   assign sig.latchLo = (state == S_ALO);
   assign sig.latchHi = (state == S_AHI);
   assign sig.cs1 = active & addrHi[AH_SEL_ONE];
   assign sig.cs2 = active & addrHi[AH_SEL_TWO];

   pin_driver driver (
      .sig(sig),
      .ctrlLo(ctrlLo),
      .muxSel(muxSel),
      .addr({addrHi, addrLo}),
      .readPin(readPin),
      .writePin(writePin),
      .bytePin(bytePin),
      .addrPin(addrPin)
   );

   // Data bus: address bytes in the latch cycles, then the data byte of the transfer
   wire [7:0] hiAddrOnBus = addrHi &
      ~{selTwoOn(csFunc), selOneOn(csFunc), 6'h00};
   assign dataOut = (state == S_ALO) ? addrLo :
      (state == S_AHI) ? hiAddrOnBus :
      byteSel ? dinHi : dinLo;
   assign dataOe = (state == S_ALO) | (state == S_AHI) | (inData & ~opRead);

   // Pin ownership: cleared enables hand the pins back to general I/O
   assign readPinEn = ctrlHi[CH_ENABLE] & ctrlHi[CH_READ_PIN_EN];
   assign writePinEn = ctrlHi[CH_ENABLE] & ctrlHi[CH_WRITE_PIN_EN];
   assign bytePinEn = ctrlHi[CH_ENABLE] & ctrlHi[CH_BYTE_PIN_EN];
   assign addrPinEn = {16{ctrlHi[CH_ENABLE]}} & {pinEnHi, pinEnLo};

endmodule : parallel_master_bus_port

// ==== verilog/pin_driver.sv ====
`timescale 1ns/10ps
module pin_driver import bus_port_pkg::*; (
   port_sig_if.drv sig,
   input wire logic [7:0] ctrlLo,
   input wire logic [1:0] muxSel,
   input wire logic [15:0] addr,
   output logic readPin,
   output logic writePin,
   output logic bytePin,
   output logic [15:0] addrPin
);
   // Polarity bit set means active high
   function automatic logic pol(input logic level, input logic activeHigh);
      return level ~^ activeHigh;
   endfunction : pol

   wire [1:0] csFunc = ctrlLo[CL_CS_FUNC +: 2];
   wire latchPol = ctrlLo[CL_LATCH_POL];
   // Shared pins: one polarity bit serves whichever function the scheme puts there
   wire readLevel = sig.combined ? sig.dirRead : sig.rdStrobe;
   wire writeLevel = sig.combined ? sig.enStrobe : sig.wrStrobe;

   assign readPin = pol(readLevel, ctrlLo[CL_READ_POL]);
   assign writePin = pol(writeLevel, ctrlLo[CL_WRITE_POL]);
   assign bytePin = pol(sig.byteEn, ctrlLo[CL_BYTE_POL]);

   assign addrPin[0] = (muxSel == MUX_PART || muxSel == MUX_FULL) ?
      pol(sig.latchLo, latchPol) : addr[0];
   assign addrPin[1] = (muxSel == MUX_FULL) ? pol(sig.latchHi, latchPol) : addr[1];
   assign addrPin[13:2] = addr[13:2];
   assign addrPin[14] = selOneOn(csFunc) ? pol(sig.cs1, ctrlLo[CL_CS1_POL]) : addr[14];
   assign addrPin[15] = selTwoOn(csFunc) ? pol(sig.cs2, ctrlLo[CL_CS2_POL]) : addr[15];
endmodule : pin_driver

// ==== verilog/port_sig_if.sv ====
`timescale 1ns/10ps
interface port_sig_if;
   logic combined;
   logic dirRead;
   logic enStrobe;
   logic rdStrobe;
   logic wrStrobe;
   logic byteEn;
   logic latchLo;
   logic latchHi;
   logic cs1;
   logic cs2;

   modport seq(output combined, dirRead, enStrobe, rdStrobe, wrStrobe, byteEn, latchLo,
      latchHi, cs1, cs2);
   modport drv(input combined, dirRead, enStrobe, rdStrobe, wrStrobe, byteEn, latchLo,
      latchHi, cs1, cs2);
endinterface : port_sig_if
